// ---- hdl/tkcc_top.sv ----
// Touch key counter control: module counters, function counter, slot timing, registers
`timescale 1ns/1ns
`include "tkcc_regs.svh"
// How it works
// - Function counter freezes at slot overflow, read-only
// - Module counters freeze at slot overflow, read-only
// - Clearing start zeroes all count pairs
// - Function counter counts over slot interval
// - Ten-bit reference capacitor code per module
// - Mux select picks key one to four
// - Doubling bit doubles key oscillator rate
// - Filter bit enables module filter
// - Hop source one means hardware hopping
// - Three-bit hop select, active with software control
// - Reference oscillator enable bit per module
// - Slot clock from reference or sys/4
// - Key oscillator enable needed to count
// - Start rising edge switches everything on
// - Slot overflow stops oscillators, sets flag
module tkcc_top (
    input  wire logic        sys_clk,         // System clock, 125 MHz
    input  wire logic        sys_rst,         // Asynchronous reset, active high
    input  wire logic        clk_en,          // Freezes all state when low
    input  wire logic [7:0]  reg_addr,        // Register byte address
    input  wire logic [7:0]  reg_wdata,       // Write data
    input  wire logic        reg_wr,          // Write strobe
    input  wire logic        reg_rd,          // Read strobe
    output logic      [7:0]  reg_rdata,       // Read data, cycle after strobe
    input  wire logic [11:0] key_osc,         // Key oscillator outputs, 4 per module
    input  wire logic [2:0]  ref_osc,         // Reference oscillator outputs
    output logic      [2:0]  ref_osc_run,     // Reference oscillator on
    output logic      [2:0]  key_osc_run,     // Key oscillator on
    output logic      [11:0] key_select,      // One-hot selected key per module
    output logic      [11:0] key_touch_pin,   // Pin given to touch sensing
    output logic      [2:0]  freq_double,     // Key oscillator doubling
    output logic      [2:0]  filter_on,       // Module filter enable
    output logic      [2:0]  hop_by_hw,       // Hardware hopping active
    output logic      [8:0]  hop_code,        // Hop frequency code, 3 per module
    output logic      [29:0] ref_cap_code,    // Capacitor code, 10 per module
    output logic             slot_overflow_flag, // Slot overflow status
    output logic             irq              // Level interrupt
);

    // Current and next state
    tkcc_pkg::tkcc_state_s st_r;
    tkcc_pkg::tkcc_state_s st_nxt;

    // Decode helpers
    logic       glob_hit;                     // Address in global space
    logic [1:0] mod_idx;                      // Addressed module
    logic       mod_hit;                      // Address in a module space
    logic [3:0] sub;                          // Module sub-offset

    always_comb
    begin
        glob_hit = (reg_addr[7:4] == 4'h0);
        mod_idx  = 2'(reg_addr[5:4] - 2'h1);
        mod_hit  = (reg_addr[7:6] == 2'h0) && (reg_addr[5:4] != 2'h0);
        sub      = reg_addr[3:0];
    end

    // Next state: bus, counters, slot timing, flags
    always_comb
    begin
        logic [2:0] set_st;                   // Events this cycle
        logic [2:0] fn_msk;                   // Prescaler compare mask
        logic       fn_tick;                  // Function counter step
        logic       start_rise;               // Start went low to high
        logic       ksel;                     // Selected key level
        logic       kedge;                    // Key count event
        logic       stick;                    // Slot clock tick
        logic [7:0] rd;                       // Read mux
        logic [3:0] kidx;                     // Selected key index
        set_st     = 3'h0;
        fn_msk     = 3'h0;
        fn_tick    = 1'b0;
        start_rise = 1'b0;
        ksel       = 1'b0;
        kedge      = 1'b0;
        stick      = 1'b0;
        rd         = `TKCC_RST_BYTE;
        kidx       = 4'h0;
        st_nxt     = st_r;

        // Register writes; counter bytes have no write path
        if (reg_wr && glob_hit)
        begin
            unique case (reg_addr)
                `TKCC_GLOB_CTRL:
                begin
                    st_nxt.start  = reg_wdata[`TKCC_START_BIT];
                    st_nxt.fn_sel = reg_wdata[`TKCC_FN_SEL_LSB +: 2];
                end
                `TKCC_SLOT_PRELOAD: st_nxt.preload = reg_wdata;
                `TKCC_IRQ_MASK:     st_nxt.mask    = reg_wdata[2:0];
                default:            ;         // Counter and status: no store
            endcase
        end
        if (reg_wr && mod_hit)
        begin
            unique case (sub)
                `TKCC_REF_CAP_LOW:  st_nxt.ref_cap[mod_idx][7:0] = reg_wdata;
                `TKCC_REF_CAP_HIGH: st_nxt.ref_cap[mod_idx][9:8] = reg_wdata[1:0];
                `TKCC_CTRL_A:       st_nxt.ctrl_a[mod_idx] = reg_wdata;
                `TKCC_CTRL_B:       st_nxt.ctrl_b[mod_idx] = reg_wdata & `TKCC_CTRL_B_MASK;
                default:            ;         // Count bytes are read only
            endcase
        end

        // Start edge against the value already held
        start_rise = st_nxt.start && !st_r.start;

        // Function counter prescaler: sys, /2, /4, /8
        st_nxt.fn_div = 3'(st_r.fn_div + 3'h1);
        fn_msk        = 3'((4'h1 << st_r.fn_sel) - 4'h1);
        fn_tick       = ((st_r.fn_div & fn_msk) == fn_msk);

        if (!st_nxt.start)
        begin
            // Stopped: counts are cleared, slot counters kept
            st_nxt.running = 1'b0;
            st_nxt.fn_cnt  = 16'h0000;
        end
        else if (start_rise)
        begin
            // Everything switched on from a clean count
            st_nxt.running = 1'b1;
            st_nxt.fn_cnt  = 16'h0000;
        end
        else if (st_r.running && fn_tick)
        begin
            // Counts over the same slot interval as the modules
            st_nxt.fn_cnt = 16'(st_r.fn_cnt + 16'h0001);
            if (st_r.fn_cnt == 16'hffff)
                set_st[`TKCC_ST_FN_OVF] = 1'b1;
        end

        // Per-module counting and slot timing
        for (int m = 0; m < tkcc_pkg::MODS; m++)
        begin
            kidx  = 4'(m * 4) + 4'(st_r.ctrl_a[m][`TKCC_MUX_LSB +: 2]);
            ksel  = key_osc[kidx];
            st_nxt.kprev[m] = ksel;
            st_nxt.rprev[m] = ref_osc[m];
            // Doubling counts both edges of the key clock
            kedge = st_r.ctrl_a[m][`TKCC_DOUBLE_BIT] ? (ksel != st_r.kprev[m])
                                                      : (ksel && !st_r.kprev[m]);
            // Slot clock: reference oscillator or system clock by four
            st_nxt.sdiv[m] = 2'(st_r.sdiv[m] + 2'h1);
            stick = st_r.ctrl_b[m][`TKCC_SLOT_SRC_BIT]
                    ? (st_r.sdiv[m] == `TKCC_SYS_DIV_LAST)
                    : (ref_osc[m] && !st_r.rprev[m] && st_r.ctrl_b[m][`TKCC_REF_EN_BIT]);
            if (!st_nxt.start)
            begin
                st_nxt.cf[m]   = 16'h0000;
                st_nxt.unit[m] = 5'h00;
                st_nxt.mrun[m] = 1'b0;
            end
            else if (start_rise)
            begin
                st_nxt.cf[m]   = 16'h0000;
                st_nxt.unit[m] = 5'h00;
                st_nxt.slot[m] = st_r.preload;
                st_nxt.mrun[m] = 1'b1;
                st_nxt.sdiv[m] = 2'h0;
            end
            else if (st_r.mrun[m])
            begin
                // Key count needs the key oscillator enabled
                if (kedge && st_r.ctrl_b[m][`TKCC_KEY_EN_BIT])
                begin
                    st_nxt.cf[m] = 16'(st_r.cf[m] + 16'h0001);
                    if (st_r.cf[m] == 16'hffff)
                        set_st[`TKCC_ST_CF_OVF] = 1'b1;
                end
                if (stick)
                begin
                    st_nxt.unit[m] = 5'(st_r.unit[m] + 5'h01);
                    if (st_r.unit[m] == `TKCC_UNIT_LAST)
                    begin
                        // Hardware hopping steps once per unit period
                        st_nxt.hop[m]  = 3'(st_r.hop[m] + 3'h3);
                        st_nxt.slot[m] = 8'(st_r.slot[m] + 8'h01);
                        if (st_r.slot[m] == `TKCC_SLOT_LAST)
                            st_nxt.mrun[m] = 1'b0; // Slot counter wraps to zero and stops
                    end
                end
            end
        end

        // Whole detection ends once every module slot has overflowed
        if (st_r.running && st_nxt.start && !start_rise && (st_nxt.mrun == 3'h0))
        begin
            st_nxt.running = 1'b0;            // Function count frozen
            set_st[`TKCC_ST_SLOT_OVF] = 1'b1;
        end

        // Sticky status: set beats a same-cycle write-one clear
        st_nxt.status = st_r.status;
        if (reg_wr && (reg_addr == `TKCC_IRQ_STATUS))
            st_nxt.status = st_r.status & ~reg_wdata[2:0];
        st_nxt.status = st_nxt.status | set_st;

        // Read mux, data stands one cycle only
        if (glob_hit)
        begin
            unique case (reg_addr)
                `TKCC_GLOB_CTRL:    rd = {2'h0, st_r.start, 3'h0, st_r.fn_sel};
                `TKCC_SLOT_PRELOAD: rd = st_r.preload;
                `TKCC_FN_CNT_LOW:   rd = st_r.fn_cnt[7:0];
                `TKCC_FN_CNT_HIGH:  rd = st_r.fn_cnt[15:8];
                `TKCC_IRQ_STATUS:   rd = {5'h00, st_r.status};
                `TKCC_IRQ_MASK:     rd = {5'h00, st_r.mask};
                default:            rd = `TKCC_RST_BYTE;     // Unmapped reads zero
            endcase
        end
        else if (mod_hit)
        begin
            unique case (sub)
                `TKCC_CF_CNT_LOW:   rd = st_r.cf[mod_idx][7:0];
                `TKCC_CF_CNT_HIGH:  rd = st_r.cf[mod_idx][15:8];
                `TKCC_REF_CAP_LOW:  rd = st_r.ref_cap[mod_idx][7:0];
                `TKCC_REF_CAP_HIGH: rd = {6'h00, st_r.ref_cap[mod_idx][9:8]};
                `TKCC_CTRL_A:       rd = st_r.ctrl_a[mod_idx];
                `TKCC_CTRL_B:       rd = st_r.ctrl_b[mod_idx];
                default:            rd = `TKCC_RST_BYTE;
            endcase
        end
        st_nxt.rdata = reg_rd ? rd : `TKCC_RST_BYTE;
    end

    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else if (clk_en)
            st_r <= st_nxt;
    end

    // Oscillator and pin controls; oscillators stop when the module slot ends
    always_comb
    begin
        for (int m = 0; m < tkcc_pkg::MODS; m++)
        begin
            ref_osc_run[m] = st_r.ctrl_b[m][`TKCC_REF_EN_BIT] && st_r.mrun[m];
            key_osc_run[m] = st_r.ctrl_b[m][`TKCC_KEY_EN_BIT] && st_r.mrun[m];
            key_select[m*4 +: 4]    = 4'(4'h1 << st_r.ctrl_a[m][`TKCC_MUX_LSB +: 2]);
            key_touch_pin[m*4 +: 4] = st_r.ctrl_b[m][3:0];
            freq_double[m] = st_r.ctrl_a[m][`TKCC_DOUBLE_BIT];
            filter_on[m]   = st_r.ctrl_a[m][`TKCC_FILTER_BIT];
            hop_by_hw[m]   = st_r.ctrl_a[m][`TKCC_HOP_SRC_BIT];
            // Software select is ignored while hardware owns hopping
            hop_code[m*3 +: 3] = hop_by_hw[m] ? st_r.hop[m]
                                              : st_r.ctrl_a[m][`TKCC_HOP_SEL_LSB +: 3];
            ref_cap_code[m*10 +: 10] = st_r.ref_cap[m];
        end
    end

    // Bus and interrupt outputs
    assign reg_rdata          = st_r.rdata;
    assign slot_overflow_flag = st_r.status[`TKCC_ST_SLOT_OVF];
    assign irq                = |(st_r.status & st_r.mask);

endmodule : tkcc_top

// ---- inc/tkcc_regs.svh ----
// Register offsets, field positions and reset values of the touch key counter block
`ifndef TKCC_REGS_SVH
`define TKCC_REGS_SVH

// Global registers
`define TKCC_GLOB_CTRL      8'h00
`define TKCC_SLOT_PRELOAD   8'h01
`define TKCC_FN_CNT_LOW     8'h02
`define TKCC_FN_CNT_HIGH    8'h03
`define TKCC_IRQ_STATUS     8'h04
`define TKCC_IRQ_MASK       8'h05

// Module n registers sit at (n + 1) * 16 plus these sub-offsets
`define TKCC_MOD_STRIDE     8'h10
`define TKCC_CF_CNT_LOW     4'h0
`define TKCC_CF_CNT_HIGH    4'h1
`define TKCC_REF_CAP_LOW    4'h2
`define TKCC_REF_CAP_HIGH   4'h3
`define TKCC_CTRL_A         4'h4
`define TKCC_CTRL_B         4'h5

// Global control fields
`define TKCC_START_BIT      5
`define TKCC_FN_SEL_LSB     0

// Module control a fields
`define TKCC_MUX_LSB        6
`define TKCC_DOUBLE_BIT     5
`define TKCC_FILTER_BIT     4
`define TKCC_HOP_SRC_BIT    3
`define TKCC_HOP_SEL_LSB    0

// Module control b fields
`define TKCC_SLOT_SRC_BIT   7
`define TKCC_REF_EN_BIT     5
`define TKCC_KEY_EN_BIT     4
`define TKCC_CTRL_B_MASK    8'hbf

// Interrupt status bits
`define TKCC_ST_SLOT_OVF    0
`define TKCC_ST_CF_OVF      1
`define TKCC_ST_FN_OVF      2

// Reset values and timing counts
`define TKCC_RST_BYTE       8'h00
`define TKCC_UNIT_LAST      5'h1f
`define TKCC_SLOT_LAST      8'hff
`define TKCC_SYS_DIV_LAST   2'h3

`endif

// ---- inc/tkcc_pkg.sv ----
// Types shared by the touch key counter block
package tkcc_pkg;

    // Number of modules and keys per module
    localparam int MODS = 3;
    localparam int KEYS = 4;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [1:0]            fn_sel;     // Function counter clock division
        logic                  start;      // Detection start control
        logic [7:0]            preload;    // Slot counter preload
        logic [15:0]           fn_cnt;     // Shared function counter
        logic [2:0]            fn_div;     // System clock prescaler
        logic [2:0]            status;     // Sticky interrupt status
        logic [2:0]            mask;       // Interrupt mask
        logic                  running;    // Detection in progress
        logic [7:0]            rdata;      // Read data register
        logic [2:0][15:0]      cf;         // Module C/F counters
        logic [2:0][9:0]       ref_cap;    // Reference capacitor codes
        logic [2:0][7:0]       ctrl_a;     // Module control a
        logic [2:0][7:0]       ctrl_b;     // Module control b
        logic [2:0][4:0]       unit;       // Slot unit period counters
        logic [2:0][7:0]       slot;       // Slot counters
        logic [2:0]            mrun;       // Module slot still running
        logic [2:0]            kprev;      // Previous selected key level
        logic [2:0]            rprev;      // Previous reference level
        logic [2:0][1:0]       sdiv;       // System clock by four dividers
        logic [2:0][2:0]       hop;        // Hardware hop sequence
    } tkcc_state_s;

endpackage : tkcc_pkg

// ---- verification/tkcc_sva.sv ----
// Port-level assertions for the touch key counter block
`timescale 1ns/1ns
module tkcc_chk (
    input wire logic        sys_clk,            // System clock
    input wire logic        sys_rst,            // Async reset
    input wire logic        clk_en,             // Clock enable
    input wire logic [7:0]  reg_addr,           // Address
    input wire logic [7:0]  reg_wdata,          // Write data
    input wire logic        reg_wr,             // Write strobe
    input wire logic        reg_rd,             // Read strobe
    input wire logic [7:0]  reg_rdata,          // Read data
    input wire logic [2:0]  ref_osc_run,        // Reference osc on
    input wire logic [2:0]  key_osc_run,        // Key osc on
    input wire logic [11:0] key_select,         // Selected keys
    input wire logic [11:0] key_touch_pin,      // Sensing pins
    input wire logic [2:0]  freq_double,        // Doubling
    input wire logic [2:0]  filter_on,          // Filter
    input wire logic [2:0]  hop_by_hw,          // Hardware hopping
    input wire logic [8:0]  hop_code,           // Hop codes
    input wire logic [29:0] ref_cap_code,       // Cap codes
    input wire logic        slot_overflow_flag  // Slot overflow
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Module 0 bus accesses; its registers drive the low output slices
    wire w0 = reg_wr && clk_en && reg_addr[7:4] == 4'h1;
    wire r0 = reg_rd && clk_en && reg_addr[7:4] == 4'h1;
    rd_quiet_a: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    hole_read_a: assert property (clk_en && reg_rd && reg_addr > 8'h05 && reg_addr < 8'h10
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    cap_unused_a: assert property (r0 && reg_addr[3:0] == 4'h3 |=>
        reg_rdata[7:2] == 6'h00) else $error("cap high spare bits set");
    ctrlb_spare_a: assert property (r0 && reg_addr[3:0] == 4'h5 |=>
        !reg_rdata[6]) else $error("control b bit 6 set");
    mux_key_a: assert property (w0 && reg_addr[3:0] == 4'h4 |=>
        key_select[3:0] == 4'h1 << $past(reg_wdata[7:6])) else $error("key select wrong");
    mode_bits_a: assert property (w0 && reg_addr[3:0] == 4'h4 |=>
        {freq_double[0], filter_on[0], hop_by_hw[0]} == $past(reg_wdata[5:3]))
        else $error("mode outputs wrong");
    hop_sel_a: assert property (w0 && reg_addr[3:0] == 4'h4 && !reg_wdata[3] |=>
        hop_code[2:0] == $past(reg_wdata[2:0])) else $error("hop code wrong");
    cap_low_a: assert property (w0 && reg_addr[3:0] == 4'h2 |=>
        ref_cap_code[7:0] == $past(reg_wdata)) else $error("cap code wrong");
    pin_claim_a: assert property (w0 && reg_addr[3:0] == 4'h5 |=>
        key_touch_pin[3:0] == $past(reg_wdata[3:0])) else $error("touch pins wrong");
    osc_start_a: assert property ($rose(key_osc_run[0]) |-> $past(reg_wr))
        else $error("key osc started without write");
    ovf_stop_a: assert property ($rose(slot_overflow_flag) |->
        (ref_osc_run | key_osc_run) == 3'h0) else $error("osc running at overflow");
    // Main scenarios reached
    cover property ($rose(slot_overflow_flag));
    cover property ($rose(ref_osc_run[0]));
    cover property ($rose(freq_double[0]));
endmodule : tkcc_chk

bind tkcc_top tkcc_chk u_chk (.*);

// ---- verification/tkcc_pads.sv ----
// Touch pad oscillator model feeding key and reference levels
`timescale 1ns/1ns
module tkcc_pads (
    input  wire logic        sys_clk,     // System clock
    input  wire logic        sys_rst,     // Async reset
    input  wire logic        slow,        // Heavier key pads, half rate
    input  wire logic [2:0]  key_osc_run, // Key oscillators on
    input  wire logic [2:0]  ref_osc_run, // Reference oscillators on
    output logic      [11:0] key_osc,     // Key levels
    output logic      [2:0]  ref_osc      // Reference levels
);
    int cnt [3];  // Half period counters
    // Module m key pads toggle every 2+m cycles, doubled when slow, reference pads every cycle; a stopped
    // oscillator rests low so no stale edge can reach a counter
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            key_osc <= 12'h000;
            ref_osc <= 3'h0;
            cnt     <= '{0, 0, 0};
        end
        else
        begin
            for (int m = 0; m < 3; m++)
            begin
                ref_osc[m] <= ref_osc_run[m] ? !ref_osc[m] : 1'b0;
                if (!key_osc_run[m])  // Stopped
                begin
                    key_osc[m*4+:4] <= 4'h0;
                    cnt[m]          <= 0;
                end
                else if (cnt[m] >= (2 + m) * (slow ? 2 : 1) - 1)  // Half period done
                begin
                    key_osc[m*4+:4] <= ~key_osc[m*4+:4];
                    cnt[m]          <= 0;
                end
                else
                    cnt[m] <= cnt[m] + 1;
            end
        end
    end
endmodule : tkcc_pads

// ---- verification/tkcc_top_tb.sv ----
// Self-checking bench for the touch key counter block
`timescale 1ns/1ns
module tkcc_top_tb;
    typedef struct {logic [7:0] a, d, e;} tkcc_row_s;  // Write, expected readback
    logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic slow = 1'b0, slot_overflow_flag, irq;           // Pad rate, status
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [11:0] key_osc, key_select, key_touch_pin;      // Key side
    logic [2:0] ref_osc, ref_osc_run, key_osc_run, freq_double, filter_on, hop_by_hw;
    logic [8:0] hop_code;                                 // Hop codes
    logic [29:0] ref_cap_code;                            // Cap codes
    logic [15:0] va [4], vb [4];                          // Count snapshots
    logic [7:0] b;                                        // Read byte
    logic [2:0] c;                                        // Field loop code
    int fails = 0, check_count = 0;
    // Readback rows; count bytes and holes must ignore writes
    tkcc_row_s rows [9] = '{'{8'h12, 8'ha5, 8'ha5}, '{8'h13, 8'hff, 8'h03},
        '{8'h15, 8'hff, 8'hbf}, '{8'h25, 8'h40, 8'h00}, '{8'h10, 8'h55, 8'h00},
        '{8'h03, 8'hff, 8'h00}, '{8'h0f, 8'h77, 8'h00}, '{8'h01, 8'hff, 8'hff},
        '{8'h33, 8'h01, 8'h01}};
    tkcc_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .key_osc(key_osc), .ref_osc(ref_osc),
        .ref_osc_run(ref_osc_run), .key_osc_run(key_osc_run), .key_select(key_select),
        .key_touch_pin(key_touch_pin), .freq_double(freq_double), .filter_on(filter_on),
        .hop_by_hw(hop_by_hw), .hop_code(hop_code), .ref_cap_code(ref_cap_code),
        .slot_overflow_flag(slot_overflow_flag), .irq(irq));
    tkcc_pads u_pads (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
        .key_osc_run(key_osc_run), .ref_osc_run(ref_osc_run), .key_osc(key_osc),
        .ref_osc(ref_osc));
    // 125 MHz clock
    initial
    begin
        forever #4 sys_clk = !sys_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Function pair then the three module pairs; low byte first
    task automatic pairs(output logic [15:0] v [4]);
        for (int i = 0; i < 4; i++)
        begin
            rd(i == 0 ? 8'h02 : 8'(16 * i), v[i][7:0]);
            rd(i == 0 ? 8'h03 : 8'(16 * i + 1), v[i][15:8]);
        end
    endtask : pairs
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chkr(input string n, input int lo, input int hi, input logic [15:0] g);
        check_count++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            fails++;
            $display("Error %s expected %0d..%0d seen %h", n, lo, hi, g);
        end
    endtask : chkr
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Start, wait for overflow under a bound, then judge counts
    task automatic run(input int s0, input logic dbl, input logic [1:0] f);
        int n = 0;
        int e;
        wr(8'h00, {6'h08, f});
        #1;
        chk("ref_osc_run", 3'h7, ref_osc_run);
        chk("key_osc_run", 3'h7, key_osc_run);
        while (slot_overflow_flag !== 1'b1 && n < 1000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 1000)
        begin
            fails++;
            $display("Error slot_overflow_flag expected 1 seen %b", slot_overflow_flag);
            finish_test();
        end
        chk("osc_stopped", 6'h00, {ref_osc_run, key_osc_run});
        pairs(va);
        chkr("fn_count", 120 >> f, 136 >> f, va[0]);
        for (int m = 0; m < 3; m++)
        begin
            e = (m == 0 ? s0 : 128) / ((2 + m) * (slow ? 2 : 1) * (m == 0 && dbl ? 1 : 2));
            chkr("cf_count", e - 3, e + 3, va[m + 1]);
        end
    endtask : run
    initial
    begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Reset values of global and module 0 registers
        for (int i = 0; i < 12; i++)
        begin
            rd(i < 6 ? 8'(i) : 8'(i + 10), b);
            chk("reset_value", 8'h00, b);
        end
        chk("key_select", 12'h111, key_select);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, b);
            chk("readback", rows[i].e, b);
        end
        chk("ref_cap_code", 10'h3a5, ref_cap_code[9:0]);
        // Every mux and hop code, and all doubling and filter pairs, on module 0
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            wr(8'h14, {c[1:0], c[0], c[1], 1'b0, c});
            #1;
            chk("key_select", 12'h110 | (12'h1 << c[1:0]), key_select);
            chk("hop_code", c, hop_code[2:0]);
            chk("freq_double", c[0], freq_double[0]);
            chk("filter_on", c[1], filter_on[0]);
            chk("hop_by_hw", 1'b0, hop_by_hw[0]);
        end
        wr(8'h14, 8'h0f);
        #1 chk("hop_by_hw", 1'b1, hop_by_hw[0]);
        chk("hop_code_hw", 3'h0, hop_code[2:0]);
        wr(8'h15, 8'h0a);
        #1 chk("key_touch_pin", 4'ha, key_touch_pin[3:0]);
        // Run on sys/4 slot clock, key 1 of each module
        wr(8'h05, 8'h01);
        for (int m = 1; m < 4; m++)
        begin
            wr(8'(16 * m + 4), 8'h00);
            wr(8'(16 * m + 5), 8'hb0);
        end
        run(128, 1'b0, 2'h0);
        chk("irq", 1'b1, irq);
        wr(8'h02, 8'hff);
        wr(8'h11, 8'hff);
        repeat (40) @(posedge sys_clk);
        pairs(vb);
        foreach (vb[i]) chk("frozen_count", va[i], vb[i]);
        wr(8'h05, 8'h00);
        #1 chk("irq_masked", 1'b0, irq);
        wr(8'h04, 8'h01);
        #1 chk("slot_overflow_flag", 1'b0, slot_overflow_flag);
        wr(8'h00, 8'h00);
        pairs(vb);
        foreach (vb[i]) chk("cleared_count", 16'h0000, vb[i]);
        // Slow pads, module 0 doubled on the reference slot clock
        slow <= 1'b1;
        wr(8'h14, 8'h20);
        wr(8'h15, 8'h30);
        run(64, 1'b1, 2'h1);
        chk("irq_masked", 1'b0, irq);
        // Reset in mid-detection must stop oscillators and zero the counts
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h20);
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 chk("key_osc_run", 3'h0, key_osc_run);
        pairs(vb);
        foreach (vb[i]) chk("reset_count", 16'h0000, vb[i]);
        finish_test();
    end
endmodule : tkcc_top_tb
